// ===== rtl/crr_pkg.sv
package crr_pkg;

	// register map, byte addresses in the data area
	localparam logic [15:0] CRR_OFS_CONTROL = 16'h0FDE;
	localparam logic [15:0] CRR_OFS_COMMIT  = 16'h0FDF;
	localparam logic [15:0] CRR_OFS_STATUS  = 16'h0FDF;

	// field positions shared by control and status
	localparam int CRR_BIT_RAM_IN_CODE  = 1;
	localparam int CRR_BIT_VECTOR_RELOC = 2;

	// values after reset
	localparam logic [7:0] CRR_RST_CONTROL = 8'h00;
	localparam logic [7:0] CRR_RST_DATA    = 8'h00;
	localparam logic       CRR_RST_BIT     = 1'b0;

	// commit code that makes staged selects active
	localparam logic [7:0] CRR_COMMIT_CODE = 8'hD4;

	// opcode returned for unmapped fetches; plain default value
	localparam logic [7:0] CRR_SOFT_TRAP_OPCODE = 8'hFF;

	// ram window, same in code and data area
	localparam logic [15:0] CRR_RAM_LO = 16'h0040;
	localparam logic [15:0] CRR_RAM_HI = 16'h0C3F;
	localparam int          CRR_RAM_AW = 12;

	// flash window in the code area
	localparam logic [15:0] CRR_FLASH_LO = 16'h1000;
	localparam logic [15:0] CRR_FLASH_HI = 16'hFFFF;

	// vector tables, high (reloc off) and ram (reloc on) placement
	localparam logic [15:0] CRR_VCALL_HI_LO = 16'hFFA0;
	localparam logic [15:0] CRR_VCALL_HI_HI = 16'hFFBF;
	localparam logic [15:0] CRR_VINT_HI_LO  = 16'hFFC8;
	localparam logic [15:0] CRR_VINT_HI_HI  = 16'hFFFF;
	localparam logic [15:0] CRR_VCALL_RM_LO = 16'h01A0;
	localparam logic [15:0] CRR_VCALL_RM_HI = 16'h01BF;
	localparam logic [15:0] CRR_VINT_RM_LO  = 16'h01C8;
	localparam logic [15:0] CRR_VINT_RM_HI  = 16'h01FD;
	localparam logic [15:0] CRR_VRESET      = 16'hFFFE;

	// entries per interrupt table; the ram copy has no reset slot
	localparam logic [4:0] CRR_VINT_HI_CNT = 5'h1C;
	localparam logic [4:0] CRR_VINT_RM_CNT = 5'h1B;

	// kind of vector lookup
	typedef enum logic [1:0] {
		CRR_VEC_CALL  = 2'h0,
		CRR_VEC_INT   = 2'h1,
		CRR_VEC_RESET = 2'h2
	} crr_vec_kind_t;

	// an access request into one 64 kbyte area
	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
	} crr_req_t;

	// select and offset towards one ram port
	typedef struct packed {
		logic                  sel;
		logic [CRR_RAM_AW-1:0] addr;
	} crr_mem_t;

	// vector lookup request
	typedef struct packed {
		logic          valid;
		crr_vec_kind_t kind;
		logic [4:0]    index;
	} crr_vec_t;

endpackage

// ===== rtl/crr_range.sv
`timescale 1ns/1ps
`default_nettype none

// inclusive address window compare
module crr_range #(
	parameter logic [15:0] LO = 16'h0000,
	parameter logic [15:0] HI = 16'hFFFF
) (
	// address under test
	input  wire logic [15:0] i_addr,
	// window hit
	output logic             o_hit
);

	assign o_hit = (i_addr >= LO) && (i_addr <= HI);

endmodule

`default_nettype wire

// ===== rtl/crr_code_map.sv
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - code and data areas are separate 64 kbyte spaces chosen by access type.
// - after reset ram appears only in the data area, not in code.
// - committed ram select maps code fetches 0x0040-0x0C3F onto ram.
// - committed relocation moves call and interrupt vectors; reset stays high.
// - serial programming mode forces ram into code window regardless of select.
// - unmapped code window fetches return the soft trap opcode.
// - relocation off: call table 0xFFA0-0xFFBF, interrupts 0xFFC8-0xFFFF.
// - relocation on: call table 0x01A0-0x01BF, interrupts 0x01C8-0x01FD.
// - writing the staged ram select changes nothing until commit.
// - control bits 7..3 read zero; selects read back; reset zero.
// - commit register is write-only; only 0xD4 latches staged selects.
// - status register reports active committed selects, not staged ones.
module crr_code_map
	import crr_pkg::*;
(
	// clock, reset, enable
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_b,
	input  wire logic        i_ce,
	// register port
	input  wire logic [15:0] i_reg_addr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	output logic      [7:0]  o_reg_rdata,
	// operating mode
	input  wire logic        i_serial_prog,
	// instruction fetch from the cpu
	input  wire crr_req_t    i_fetch,
	output logic      [7:0]  o_fetch_data,
	output logic             o_fetch_valid,
	output logic      [1:0]  o_fetch_tbl,
	// code side memories
	output crr_mem_t         o_ram_code,
	input  wire logic [7:0]  i_ram_code_rdata,
	output logic             o_flash_sel,
	output logic      [15:0] o_flash_addr,
	input  wire logic [7:0]  i_flash_rdata,
	// data transfer access
	input  wire crr_req_t    i_data,
	output crr_mem_t         o_ram_data,
	// vector lookup
	input  wire crr_vec_t    i_vec,
	output logic      [15:0] o_vec_addr,
	output logic             o_vec_valid,
	output logic             o_vec_err,
	// effective mapping
	output logic             o_ram_in_code
);

	// staged selects, written by software
	logic        ram_in_code_stage_q;
	logic        vector_reloc_stage_q;
	// active selects, loaded only by commit
	logic        ram_in_code_active_q;
	logic        vector_reloc_active_q;
	// register read path
	logic [7:0]  rdata_d;
	logic [7:0]  rdata_q;
	// fetch return path
	logic [7:0]  fetch_data_d;
	logic [7:0]  fetch_data_q;
	logic        fetch_valid_q;
	logic [1:0]  fetch_tbl_d;
	logic [1:0]  fetch_tbl_q;
	// vector path
	logic [15:0] vec_addr_d;
	logic [15:0] vec_addr_q;
	logic        vec_err_d;
	logic        vec_err_q;
	logic        vec_valid_q;
	// decode terms
	logic        wr_control;
	logic        wr_commit;
	logic        commit_ok;
	logic        ram_map_en;
	logic        f_ram_hit;
	logic        f_flash_hit;
	logic        d_ram_hit;
	logic        vcall_hi_hit;
	logic        vint_hi_hit;
	logic        vcall_rm_hit;
	logic        vint_rm_hit;
	logic        vcall_hit;
	logic        vint_hit;
	logic [15:0] f_ram_ofs;
	logic [15:0] d_ram_ofs;

	// register write decode
	assign wr_control = i_reg_wr && (i_reg_addr == CRR_OFS_CONTROL);
	assign wr_commit  = i_reg_wr && (i_reg_addr == CRR_OFS_COMMIT);
	assign commit_ok  = wr_commit && (i_reg_wdata == CRR_COMMIT_CODE);

	// staged selects; these never steer the decode directly
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ram_in_code_stage_q  <= CRR_RST_BIT;
			vector_reloc_stage_q <= CRR_RST_BIT;
		end else if (i_ce && wr_control) begin
			ram_in_code_stage_q  <= i_reg_wdata[CRR_BIT_RAM_IN_CODE];
			vector_reloc_stage_q <= i_reg_wdata[CRR_BIT_VECTOR_RELOC];
		end
	end

	// commit copies staged selects to the active pair
	// a write that stages and commits cannot collide: one strobe per cycle
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			ram_in_code_active_q  <= CRR_RST_BIT;
			vector_reloc_active_q <= CRR_RST_BIT;
		end else if (i_ce && commit_ok) begin
			ram_in_code_active_q  <= ram_in_code_stage_q;
			vector_reloc_active_q <= vector_reloc_stage_q;
		end
	end

	// serial programming overrides the select
	assign ram_map_en    = ram_in_code_active_q || i_serial_prog;
	assign o_ram_in_code = ram_map_en;

	// read mux; commit address reads back the status view
	always_comb begin
		rdata_d = CRR_RST_DATA;
		if (i_reg_addr == CRR_OFS_CONTROL) begin
			rdata_d[CRR_BIT_RAM_IN_CODE]  = ram_in_code_stage_q;
			rdata_d[CRR_BIT_VECTOR_RELOC] = vector_reloc_stage_q;
		end else if (i_reg_addr == CRR_OFS_STATUS) begin
			rdata_d[CRR_BIT_RAM_IN_CODE]  = ram_in_code_active_q;
			rdata_d[CRR_BIT_VECTOR_RELOC] = vector_reloc_active_q;
		end
	end

	// read data stands one cycle after the strobe only
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rdata_q <= CRR_RST_DATA;
		end else if (i_ce) begin
			rdata_q <= i_reg_rd ? rdata_d : CRR_RST_DATA;
		end
	end
	assign o_reg_rdata = rdata_q;

	// code area windows
	crr_range #(
		.LO (CRR_RAM_LO),
		.HI (CRR_RAM_HI)
	) u_f_ram (
		.i_addr (i_fetch.addr),
		.o_hit  (f_ram_hit)
	);

	crr_range #(
		.LO (CRR_FLASH_LO),
		.HI (CRR_FLASH_HI)
	) u_f_flash (
		.i_addr (i_fetch.addr),
		.o_hit  (f_flash_hit)
	);

	// data area ram window, independent of code mapping
	crr_range #(
		.LO (CRR_RAM_LO),
		.HI (CRR_RAM_HI)
	) u_d_ram (
		.i_addr (i_data.addr),
		.o_hit  (d_ram_hit)
	);

	// vector table windows, both placements
	crr_range #(
		.LO (CRR_VCALL_HI_LO),
		.HI (CRR_VCALL_HI_HI)
	) u_vcall_hi (
		.i_addr (i_fetch.addr),
		.o_hit  (vcall_hi_hit)
	);

	crr_range #(
		.LO (CRR_VINT_HI_LO),
		.HI (CRR_VINT_HI_HI)
	) u_vint_hi (
		.i_addr (i_fetch.addr),
		.o_hit  (vint_hi_hit)
	);

	crr_range #(
		.LO (CRR_VCALL_RM_LO),
		.HI (CRR_VCALL_RM_HI)
	) u_vcall_rm (
		.i_addr (i_fetch.addr),
		.o_hit  (vcall_rm_hit)
	);

	crr_range #(
		.LO (CRR_VINT_RM_LO),
		.HI (CRR_VINT_RM_HI)
	) u_vint_rm (
		.i_addr (i_fetch.addr),
		.o_hit  (vint_rm_hit)
	);

	// table hits follow the active relocation select
	assign vcall_hit = vector_reloc_active_q ? vcall_rm_hit
	                                         : vcall_hi_hit;
	assign vint_hit  = vector_reloc_active_q ? vint_rm_hit
	                                         : vint_hi_hit;

	// ram offsets from the window base
	assign f_ram_ofs = i_fetch.addr - CRR_RAM_LO;
	assign d_ram_ofs = i_data.addr - CRR_RAM_LO;

	// code fetch routing; the ram port is a separate space from data
	assign o_ram_code.sel  = i_fetch.valid && f_ram_hit && ram_map_en;
	assign o_ram_code.addr = f_ram_ofs[CRR_RAM_AW-1:0];
	assign o_flash_sel     = i_fetch.valid && f_flash_hit;
	assign o_flash_addr    = i_fetch.addr;

	// data transfers always reach ram in its window
	assign o_ram_data.sel  = i_data.valid && d_ram_hit;
	assign o_ram_data.addr = d_ram_ofs[CRR_RAM_AW-1:0];

	// fetch return byte; holes and the unmapped window give the trap
	always_comb begin
		fetch_data_d = CRR_SOFT_TRAP_OPCODE;
		if (f_ram_hit && ram_map_en) begin
			fetch_data_d = i_ram_code_rdata;
		end else if (f_flash_hit) begin
			fetch_data_d = i_flash_rdata;
		end
		fetch_tbl_d = {vint_hit, vcall_hit};
	end

	// fetch data registered one cycle after the request
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			fetch_data_q  <= CRR_RST_DATA;
			fetch_tbl_q   <= 2'h0;
			fetch_valid_q <= 1'b0;
		end else if (i_ce) begin
			fetch_valid_q <= i_fetch.valid;
			if (i_fetch.valid) begin
				fetch_data_q <= fetch_data_d;
				fetch_tbl_q  <= fetch_tbl_d;
			end
		end
	end
	assign o_fetch_data  = fetch_data_q;
	assign o_fetch_tbl   = fetch_tbl_q;
	assign o_fetch_valid = fetch_valid_q;

	// vector address: base plus two bytes per entry
	// the reset vector ignores relocation so a bad ram image cannot brick boot
	always_comb begin
		vec_addr_d = CRR_VRESET;
		vec_err_d  = 1'b0;
		unique case (i_vec.kind)
			CRR_VEC_CALL: begin
				vec_addr_d = (vector_reloc_active_q ? CRR_VCALL_RM_LO
				                                    : CRR_VCALL_HI_LO)
				             + {11'h000, i_vec.index[3:0], 1'b0};
				vec_err_d  = i_vec.index[4];
			end
			CRR_VEC_INT: begin
				vec_addr_d = (vector_reloc_active_q ? CRR_VINT_RM_LO
				                                    : CRR_VINT_HI_LO)
				             + {10'h000, i_vec.index, 1'b0};
				vec_err_d  = vector_reloc_active_q
				             ? (i_vec.index >= CRR_VINT_RM_CNT)
				             : (i_vec.index >= CRR_VINT_HI_CNT);
			end
			CRR_VEC_RESET: begin
				vec_addr_d = CRR_VRESET;
			end
			default: begin
				vec_addr_d = CRR_VRESET;
				vec_err_d  = 1'b1;
			end
		endcase
	end

	// vector result registered one cycle after the lookup
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b) begin
			vec_addr_q  <= CRR_VRESET;
			vec_err_q   <= 1'b0;
			vec_valid_q <= 1'b0;
		end else if (i_ce) begin
			vec_valid_q <= i_vec.valid;
			if (i_vec.valid) begin
				vec_addr_q <= vec_addr_d;
				vec_err_q  <= vec_err_d;
			end
		end
	end
	assign o_vec_addr  = vec_addr_q;
	assign o_vec_err   = vec_err_q;
	assign o_vec_valid = vec_valid_q;

endmodule

`default_nettype wire

// ===== tb/crr_code_map_chk.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the code area decode
module crr_code_map_chk
	import crr_pkg::*;
(
	// clock, reset, enable
	input wire logic        i_clk_sys,
	input wire logic        i_rst_b,
	input wire logic        i_ce,
	// register port
	input wire logic [15:0] i_reg_addr,
	input wire logic [7:0]  i_reg_wdata,
	input wire logic        i_reg_wr,
	input wire logic        i_reg_rd,
	input wire logic [7:0]  o_reg_rdata,
	// fetch, data and vector paths
	input wire logic        i_serial_prog,
	input wire crr_req_t    i_fetch,
	input wire logic [7:0]  o_fetch_data,
	input wire crr_mem_t    o_ram_code,
	input wire logic        o_flash_sel,
	input wire logic [15:0] o_flash_addr,
	input wire crr_req_t    i_data,
	input wire crr_mem_t    o_ram_data,
	input wire crr_vec_t    i_vec,
	input wire logic [15:0] o_vec_addr,
	input wire logic        o_ram_in_code
);
	logic fwin;
	logic dwin;
	logic commit;
	// window hits and the one write that may move the map
	assign fwin = i_fetch.addr >= CRR_RAM_LO && i_fetch.addr <= CRR_RAM_HI;
	assign dwin = i_data.addr >= CRR_RAM_LO && i_data.addr <= CRR_RAM_HI;
	assign commit = i_ce && i_reg_wr && i_reg_addr == CRR_OFS_COMMIT
		&& i_reg_wdata == CRR_COMMIT_CODE;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_b);
	a_trap_unmapped: assert property (i_ce && i_fetch.valid && fwin
		&& !o_ram_in_code |=> o_fetch_data == CRR_SOFT_TRAP_OPCODE)
		else $error("unmapped fetch did not trap");
	a_ram_select: assert property (i_fetch.valid && fwin && o_ram_in_code
		|-> o_ram_code.sel && o_ram_code.addr == 12'(i_fetch.addr - 16'h0040))
		else $error("code ram select wrong");
	a_serial_force: assert property (i_serial_prog |-> o_ram_in_code)
		else $error("serial mode without ram");
	a_data_ram: assert property (i_data.valid && dwin |-> o_ram_data.sel)
		else $error("data ram not selected");
	a_flash_path: assert property (i_fetch.valid
		&& i_fetch.addr >= 16'h1000
		|-> o_flash_sel && o_flash_addr == i_fetch.addr)
		else $error("flash path wrong");
	a_map_hold: assert property (!o_ram_in_code && !i_serial_prog
		&& !commit |=> !o_ram_in_code || i_serial_prog)
		else $error("map moved without commit");
	a_vec_reset: assert property (i_ce && i_vec.valid
		&& i_vec.kind == CRR_VEC_RESET |=> o_vec_addr == CRR_VRESET)
		else $error("reset vector moved");
	a_read_idle: assert property (i_ce && !i_reg_rd
		|=> o_reg_rdata == 8'h00)
		else $error("read data outside read");
endmodule
bind crr_code_map crr_code_map_chk u_chk (.i_clk_sys(i_clk_sys),
	.i_rst_b(i_rst_b), .i_ce(i_ce), .i_reg_addr(i_reg_addr),
	.i_reg_wdata(i_reg_wdata),
	.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
	.i_serial_prog(i_serial_prog), .i_fetch(i_fetch),
	.o_fetch_data(o_fetch_data), .o_ram_code(o_ram_code),
	.o_flash_sel(o_flash_sel), .o_flash_addr(o_flash_addr), .i_data(i_data),
	.o_ram_data(o_ram_data), .i_vec(i_vec), .o_vec_addr(o_vec_addr),
	.o_ram_in_code(o_ram_in_code));
`default_nettype wire

// ===== tb/crr_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// code-side ram and flash, combinational read
module crr_mem_model
	import crr_pkg::*;
(
	// clock and reset
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst_b,
	// memory ports
	input  wire crr_mem_t    i_ram,
	input  wire logic        i_flash_sel,
	input  wire logic [15:0] i_flash_addr,
	output logic      [7:0]  o_ram_rdata,
	output logic      [7:0]  o_flash_rdata
);
	logic [7:0] junk_q;
	// deselected lines move every cycle so a stale byte never passes
	always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
		if (!i_rst_b)
			junk_q <= 8'h00;
		else
			junk_q <= junk_q + 8'h6B;
	end
	// bytes are never loaded; each is a fixed function of offset or address
	assign o_ram_rdata   = i_ram.sel ? i_ram.addr[7:0] ^ 8'hA5 : junk_q;
	assign o_flash_rdata = i_flash_sel ? i_flash_addr[7:0] ^ 8'h3C : junk_q;
endmodule
`default_nettype wire

// ===== tb/code_area_ram_remap_tb.sv
`timescale 1ns/1ps
`default_nettype none
module code_area_ram_remap_tb
	import crr_pkg::*;
;
	logic        i_clk_sys, i_rst_b, i_ce, i_reg_wr, i_reg_rd, i_serial_prog;
	logic [15:0] i_reg_addr, o_flash_addr, o_vec_addr;
	logic [7:0]  i_reg_wdata, o_reg_rdata, o_fetch_data, ram_rd, fl_rd;
	logic        o_fetch_valid, o_flash_sel, o_vec_valid, o_vec_err;
	logic        o_ram_in_code;
	logic [1:0]  o_fetch_tbl;
	crr_req_t    i_fetch, i_data;
	crr_mem_t    o_ram_code, o_ram_data;
	crr_vec_t    i_vec;
	int          err_total, samples_checked, cyc;
	localparam logic [7:0] TRAP = CRR_SOFT_TRAP_OPCODE;

	crr_code_map uut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce),
		.i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
		.i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
		.i_serial_prog(i_serial_prog), .i_fetch(i_fetch),
		.o_fetch_data(o_fetch_data), .o_fetch_valid(o_fetch_valid),
		.o_fetch_tbl(o_fetch_tbl), .o_ram_code(o_ram_code),
		.i_ram_code_rdata(ram_rd), .o_flash_sel(o_flash_sel),
		.o_flash_addr(o_flash_addr), .i_flash_rdata(fl_rd), .i_data(i_data),
		.o_ram_data(o_ram_data), .i_vec(i_vec), .o_vec_addr(o_vec_addr),
		.o_vec_valid(o_vec_valid), .o_vec_err(o_vec_err),
		.o_ram_in_code(o_ram_in_code));
	crr_mem_model u_mem (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
		.i_ram(o_ram_code), .i_flash_sel(o_flash_sel),
		.i_flash_addr(o_flash_addr), .o_ram_rdata(ram_rd), .o_flash_rdata(fl_rd));

	// 25 MHz system clock
	initial begin
		i_clk_sys = 1'b0;
		forever #20 i_clk_sys = ~i_clk_sys;
	end
	// hang guard, well above the fewer than a hundred cycles the run needs
	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			close_out();
		end
	end
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [16:0] got, input logic [16:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_reg_addr  <= a;
		i_reg_wdata <= d;
		i_reg_wr    <= 1'b1;
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] e);
		@(posedge i_clk_sys);
		i_reg_addr <= a;
		i_reg_rd   <= 1'b1;
		@(posedge i_clk_sys);
		i_reg_rd <= 1'b0;
		#1 chk(17'(o_reg_rdata), 17'(e));
	endtask
	// one fetch; valid and byte stand in the cycle after the request
	task automatic fe(input logic [15:0] a, input logic [7:0] e);
		@(posedge i_clk_sys);
		i_fetch <= '{1'b1, a};
		@(posedge i_clk_sys);
		i_fetch <= '0;
		#1 chk({o_fetch_valid, o_fetch_data}, {1'b1, e});
	endtask
	// one fetch; table hit flags stand beside the returned byte
	task automatic ft(input logic [15:0] a, input logic [1:0] e);
		@(posedge i_clk_sys);
		i_fetch <= '{1'b1, a};
		@(posedge i_clk_sys);
		i_fetch <= '0;
		#1 chk({o_fetch_valid, 14'h0000, o_fetch_tbl}, {1'b1, 14'h0000, e});
	endtask
	// mid-run reset must drop any committed mapping
	task automatic t_reset();
		@(posedge i_clk_sys);
		i_rst_b <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		chk(17'(o_ram_in_code), 17'h0_0000);
		fe(16'h0040, TRAP);
		rd(CRR_OFS_STATUS, 8'h00);
		rd(CRR_OFS_CONTROL, 8'h00);
		$display("reset test done");
	endtask
	task automatic vc(input crr_vec_kind_t k, input logic [4:0] n,
		input logic [16:0] e);
		@(posedge i_clk_sys);
		i_vec <= '{1'b1, k, n};
		@(posedge i_clk_sys);
		i_vec <= '0;
		#1 chk({o_vec_err, o_vec_addr}, e);
		chk(17'(o_vec_valid), 17'h0_0001);
	endtask
	task automatic t_staged();
		rd(CRR_OFS_CONTROL, 8'h00);
		rd(CRR_OFS_STATUS, 8'h00);
		wr(CRR_OFS_CONTROL, 8'hFF);
		rd(CRR_OFS_CONTROL, 8'h06);
		rd(CRR_OFS_STATUS, 8'h00);
		rd(16'h0FD0, 8'h00);
		fe(16'h0040, TRAP);
		fe(16'h0C3F, TRAP);
		chk(17'(o_ram_in_code), 17'h0_0000);
		ft(16'hFFA0, 2'h1);
		ft(16'hFFFF, 2'h2);
		ft(16'h01A0, 2'h0);
		vc(CRR_VEC_CALL, 5'h0F, {1'b0, 16'hFFBE});
		vc(CRR_VEC_INT, 5'h00, {1'b0, 16'hFFC8});
		$display("staged test done");
	endtask
	task automatic t_commit();
		wr(CRR_OFS_COMMIT, 8'h55);
		rd(CRR_OFS_STATUS, 8'h00);
		wr(CRR_OFS_COMMIT, CRR_COMMIT_CODE);
		fe(16'h0040, 8'hA5);
		rd(CRR_OFS_STATUS, 8'h06);
		fe(16'h0C3F, 8'h5A);
		fe(16'h0C40, TRAP);
		fe(16'h1000, 8'h3C);
		chk(17'(o_ram_in_code), 17'h0_0001);
		ft(16'h01BF, 2'h1);
		ft(16'h01FD, 2'h2);
		ft(16'hFFC8, 2'h0);
		vc(CRR_VEC_CALL, 5'h00, {1'b0, 16'h01A0});
		vc(CRR_VEC_INT, 5'h1A, {1'b0, 16'h01FC});
		vc(CRR_VEC_INT, 5'h1B, {1'b1, 16'h01FE});
		vc(CRR_VEC_RESET, 5'h00, {1'b0, CRR_VRESET});
		$display("commit test done");
	endtask
	task automatic t_serial();
		wr(CRR_OFS_CONTROL, 8'h04);
		wr(CRR_OFS_COMMIT, CRR_COMMIT_CODE);
		rd(CRR_OFS_STATUS, 8'h04);
		fe(16'h0041, TRAP);
		@(posedge i_clk_sys);
		i_serial_prog <= 1'b1;
		i_data        <= '{1'b1, 16'h0C3F};
		fe(16'h0041, 8'hA4);
		chk(17'(o_ram_in_code), 17'h0_0001);
		chk(17'(o_ram_data), 17'({1'b1, 12'hBFF}));
		$display("serial test done");
	endtask
	initial begin
		{i_rst_b, i_reg_wr, i_reg_rd, i_serial_prog} = '0;
		{i_reg_addr, i_reg_wdata, i_fetch, i_data, i_vec} = '0;
		{err_total, samples_checked, cyc} = '0;
		i_ce = 1'b1;
		repeat (3) @(posedge i_clk_sys);
		i_rst_b <= 1'b1;
		t_staged();
		t_commit();
		t_reset();
		t_serial();
		close_out();
	end
endmodule
`default_nettype wire
